// *** design/scmc_regs.svh ***
// Register offsets, field positions, reset values for sync/mode control
`ifndef SCMC_REGS_SVH
`define SCMC_REGS_SVH
// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SCMC_SYNC_IDX      12'h1ff
`define SCMC_MODE_IDX      12'h200
`define SCMC_STAT_IDX      12'h202
`define SCMC_SYNC_ADDR     (`SCMC_SYNC_IDX << 2)
`define SCMC_MODE_ADDR     (`SCMC_MODE_IDX << 2)
`define SCMC_STAT_ADDR     (`SCMC_STAT_IDX << 2)
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SCMC_SYNC_MODE_BIT 0
`define SCMC_Q_IGNORE_BIT  5
`define SCMC_RSVD_BIT      4
`define SCMC_APP_LSB       0
`define SCMC_APP_MSB       3
`define SCMC_PHERR_BIT     8
`define SCMC_SYNC_RST      1'h0
`define SCMC_MODE_RST      8'h00
`define SCMC_APP_FULL_BW   4'h0
`define SCMC_APP_ONE_DDC   4'h1
`define SCMC_RESP_OKAY     2'h0
`define SCMC_RESP_SLVERR   2'h2
`endif

// *** design/scmc_pkg.sv ***
// Types for sync and chip mode control
package scmc_pkg;
    // ----------------------------------------
    // AXI4-Lite carriers
    // ----------------------------------------
    typedef struct packed {
        logic        awvalid;
        logic [13:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [13:0] araddr;
        logic        rready;
    } scmc_axil_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scmc_axil_rsp_t;
    // ----------------------------------------
    // Sync modes
    // ----------------------------------------
    typedef enum logic {
        SCMC_DIV_RESET  = 1'b0,
        SCMC_TIME_STAMP = 1'b1
    } scmc_sync_mode_t;
endpackage

// *** design/scmc_top.sv ***
// Sync mode and chip mode register bank with SYSREF handling
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "scmc_regs.svh"
module scmc_top
    import scmc_pkg::*;
#(
    parameter int DIV_RATIO = 4,
    parameter int DIVW      = 3,
    parameter int SW        = 16
)(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            ce,
    input  wire scmc_axil_req_t  s_axil_req,
    output      scmc_axil_rsp_t  s_axil_rsp,
    input  wire logic            sysref_pin,
    input  wire logic            smp_valid,
    input  wire logic [SW-1:0]   smp_i,
    input  wire logic [SW-1:0]   smp_q,
    output      logic            out_valid_q,
    output      logic [SW-1:0]   out_i_q,
    output      logic [SW-1:0]   out_q_q,
    output      logic            out_ctrl_q,
    output      logic [DIVW-1:0] div_phase_q,
    output      logic            div_reset_q,
    output      logic            link_drop_q,
    output      logic            monitor_sync_q,
    output      logic            q_enable,
    output      logic            full_bw_mode,
    output      logic            ddc0_only_mode,
    output      logic [3:0]      app_mode
);
    // ----------------------------------------
    // Register bus state
    // ----------------------------------------
    logic        aw_v_q, aw_v_d, w_v_q, w_v_d;
    logic [13:0] aw_a_q, aw_a_d;
    logic [31:0] w_dat_q, w_dat_d;
    logic [3:0]  w_stb_q, w_stb_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        sync_mode_q, sync_mode_d;
    logic [7:0]  mode_q, mode_d;
    logic        pherr_clr;
    logic        pherr_q, pherr_d;
    logic [7:0]  sysref_cnt_q, sysref_cnt_d;

    always_comb
    begin
        aw_v_d      = aw_v_q;
        aw_a_d      = aw_a_q;
        w_v_d       = w_v_q;
        w_dat_d     = w_dat_q;
        w_stb_d     = w_stb_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        rvalid_d    = rvalid_q;
        rresp_d     = rresp_q;
        rdata_d     = rdata_q;
        sync_mode_d = sync_mode_q;
        mode_d      = mode_q;
        pherr_clr   = 1'b0;
        if (s_axil_req.awvalid && !aw_v_q && !bvalid_q)
        begin
            aw_v_d = 1'b1;
            aw_a_d = s_axil_req.awaddr;
        end
        if (s_axil_req.wvalid && !w_v_q && !bvalid_q)
        begin
            w_v_d   = 1'b1;
            w_dat_d = s_axil_req.wdata;
            w_stb_d = s_axil_req.wstrb;
        end
        if (aw_v_q && w_v_q && !bvalid_q)
        begin
            aw_v_d   = 1'b0;
            w_v_d    = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = `SCMC_RESP_OKAY;
            unique case (aw_a_q[13:2])
                `SCMC_SYNC_IDX:
                    if (w_stb_q[0])
                        sync_mode_d = w_dat_q[`SCMC_SYNC_MODE_BIT];
                `SCMC_MODE_IDX:
                    if (w_stb_q[0])
                    begin
                        mode_d = w_dat_q[7:0];
                        mode_d[`SCMC_RSVD_BIT] = 1'b0;
                    end
                `SCMC_STAT_IDX:
                    pherr_clr = w_stb_q[1] && w_dat_q[`SCMC_PHERR_BIT];
                default:
                    bresp_d = `SCMC_RESP_SLVERR;
            endcase
        end
        if (bvalid_q && s_axil_req.bready)
            bvalid_d = 1'b0;
        if (rvalid_q && s_axil_req.rready)
            rvalid_d = 1'b0;
        if (s_axil_req.arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = `SCMC_RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            unique case (s_axil_req.araddr[13:2])
                `SCMC_SYNC_IDX:
                    rdata_d[`SCMC_SYNC_MODE_BIT] = sync_mode_q;
                `SCMC_MODE_IDX:
                    rdata_d[7:0] = mode_q;
                `SCMC_STAT_IDX:
                    rdata_d[8:0] = {pherr_q, sysref_cnt_q};
                default:
                    rresp_d = `SCMC_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_v_q      <= 1'b0;
            aw_a_q      <= 14'h0000;
            w_v_q       <= 1'b0;
            w_dat_q     <= 32'h0000_0000;
            w_stb_q     <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_q     <= 2'h0;
            rvalid_q    <= 1'b0;
            rresp_q     <= 2'h0;
            rdata_q     <= 32'h0000_0000;
            sync_mode_q <= `SCMC_SYNC_RST;
            mode_q      <= `SCMC_MODE_RST;
        end
        else if (ce)
        begin
            aw_v_q      <= aw_v_d;
            aw_a_q      <= aw_a_d;
            w_v_q       <= w_v_d;
            w_dat_q     <= w_dat_d;
            w_stb_q     <= w_stb_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rresp_q     <= rresp_d;
            rdata_q     <= rdata_d;
            sync_mode_q <= sync_mode_d;
            mode_q      <= mode_d;
        end
    end

    always_comb
    begin
        s_axil_rsp.awready = !aw_v_q && !bvalid_q;
        s_axil_rsp.wready  = !w_v_q && !bvalid_q;
        s_axil_rsp.bvalid  = bvalid_q;
        s_axil_rsp.bresp   = bresp_q;
        s_axil_rsp.arready = !rvalid_q;
        s_axil_rsp.rvalid  = rvalid_q;
        s_axil_rsp.rdata   = rdata_q;
        s_axil_rsp.rresp   = rresp_q;
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    assign q_enable       = !mode_q[`SCMC_Q_IGNORE_BIT];
    assign app_mode       = mode_q[`SCMC_APP_MSB:`SCMC_APP_LSB];
    assign full_bw_mode   = (app_mode == `SCMC_APP_FULL_BW);
    assign ddc0_only_mode = (app_mode == `SCMC_APP_ONE_DDC);

    // ----------------------------------------
    // SYSREF capture, dividers, data path
    // ----------------------------------------
    logic [2:0]      sr_sync_q;
    logic            sr_lvl_q, sr_lvl_d, sr_edge;
    logic [DIVW-1:0] div_d;
    logic            div_rst_d, drop_d, mon_d;
    logic            ts_pend_q, ts_pend_d;
    logic            ov_d, oc_d;
    logic [SW-1:0]   oi_d, oq_d;
    scmc_sync_mode_t smode;

    assign smode   = scmc_sync_mode_t'(sync_mode_q);
    assign sr_edge = sr_sync_q[1] && sr_sync_q[2] && !sr_lvl_q;

    always_comb
    begin
        sr_lvl_d     = sr_lvl_q;
        div_d        = div_phase_q;
        div_rst_d    = 1'b0;
        drop_d       = 1'b0;
        mon_d        = 1'b0;
        pherr_d      = pherr_q;
        sysref_cnt_d = sysref_cnt_q;
        ts_pend_d    = ts_pend_q;
        ov_d         = smp_valid;
        oi_d         = out_i_q;
        oq_d         = out_q_q;
        oc_d         = 1'b0;
        if (sr_sync_q[1] == sr_sync_q[2])
            sr_lvl_d = sr_sync_q[1];
        if (div_phase_q == DIVW'(DIV_RATIO - 1))
            div_d = '0;
        else
            div_d = div_phase_q + 1'b1;
        if (pherr_clr)
            pherr_d = 1'b0;
        if (sr_edge)
            sysref_cnt_d = sysref_cnt_q + 1'b1;
        if (sr_edge && smode == SCMC_DIV_RESET)
        begin
            div_d     = '0;
            div_rst_d = 1'b1;
            mon_d     = 1'b1;
            if (div_phase_q != '0)
            begin
                drop_d  = 1'b1;
                pherr_d = 1'b1;
            end
        end
        // Time-stamp mode: dividers run on, link and monitor untouched
        if (smp_valid)
        begin
            oi_d      = smp_i;
            oq_d      = q_enable ? smp_q : '0;
            oc_d      = ts_pend_q || (sr_edge && smode == SCMC_TIME_STAMP);
            ts_pend_d = 1'b0;
        end
        else if (sr_edge && smode == SCMC_TIME_STAMP)
            ts_pend_d = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sr_sync_q      <= 3'h0;
            sr_lvl_q       <= 1'b0;
            div_phase_q    <= '0;
            div_reset_q    <= 1'b0;
            link_drop_q    <= 1'b0;
            monitor_sync_q <= 1'b0;
            pherr_q        <= 1'b0;
            sysref_cnt_q   <= 8'h00;
            ts_pend_q      <= 1'b0;
            out_valid_q    <= 1'b0;
            out_i_q        <= '0;
            out_q_q        <= '0;
            out_ctrl_q     <= 1'b0;
        end
        else if (ce)
        begin
            sr_sync_q      <= {sr_sync_q[1:0], sysref_pin};
            sr_lvl_q       <= sr_lvl_d;
            div_phase_q    <= div_d;
            div_reset_q    <= div_rst_d;
            link_drop_q    <= drop_d;
            monitor_sync_q <= mon_d;
            pherr_q        <= pherr_d;
            sysref_cnt_q   <= sysref_cnt_d;
            ts_pend_q      <= ts_pend_d;
            out_valid_q    <= ov_d;
            out_i_q        <= oi_d;
            out_q_q        <= oq_d;
            out_ctrl_q     <= oc_d;
        end
    end
endmodule

// *** dv/scmc_properties.sv ***
// Checker for sync and chip mode control
`timescale 1ns/1ps
module scmc_properties
    import scmc_pkg::*;
#(
    parameter int DIV_RATIO = 4,
    parameter int DIVW      = 3,
    parameter int SW        = 16
)(
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            ce,
    input wire logic            out_valid_q,
    input wire logic [SW-1:0]   out_q_q,
    input wire logic            out_ctrl_q,
    input wire logic [DIVW-1:0] div_phase_q,
    input wire logic            div_reset_q,
    input wire logic            link_drop_q,
    input wire logic            monitor_sync_q,
    input wire logic            q_enable,
    input wire logic            full_bw_mode,
    input wire logic            ddc0_only_mode,
    input wire logic [3:0]      app_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence run_s;
        (aresetn && ce) ##1 (ce && !div_reset_q);
    endsequence
    phase_step_a: assert property (run_s |->
        div_phase_q == DIVW'(($past(div_phase_q) + 1) % DIV_RATIO))
        else $error("divider did not advance");
    zero_on_sync_a: assert property (
        div_reset_q |-> div_phase_q == '0)
        else $error("divider not cleared");
    pulse_once_a: assert property (div_reset_q |=> !div_reset_q)
        else $error("divider reset too long");
    monitor_tie_a: assert property (monitor_sync_q == div_reset_q)
        else $error("monitor sync mismatch");
    drop_cause_a: assert property (link_drop_q |-> div_reset_q)
        else $error("link drop without sync");
    drop_phase_a: assert property (div_reset_q |->
        link_drop_q == ($past(div_phase_q) != '0))
        else $error("link drop wrong");
    q_gone_a: assert property (out_valid_q && !q_enable &&
        $stable(q_enable) |-> out_q_q == '0)
        else $error("quadrature not dropped");
    mark_valid_a: assert property (out_ctrl_q |-> out_valid_q)
        else $error("mark without sample");
    app_decode_a: assert property (
        full_bw_mode == (app_mode == 4'h0)
        && ddc0_only_mode == (app_mode == 4'h1))
        else $error("app mode decode wrong");
endmodule
bind scmc_top scmc_properties #(.DIV_RATIO(DIV_RATIO), .DIVW(DIVW),
    .SW(SW)) scmc_properties_inst (.aclk, .aresetn, .ce, .out_valid_q,
    .out_q_q, .out_ctrl_q, .div_phase_q, .div_reset_q, .link_drop_q,
    .monitor_sync_q, .q_enable, .full_bw_mode, .ddc0_only_mode, .app_mode);

// *** dv/scmc_sysref_src.sv ***
// Model of the source of the alignment pulse
`timescale 1ns/1ps
module scmc_sysref_src #(
    parameter int HIGH_CYC = 6
)(
    input  wire logic aclk,
    input  wire logic fire,
    output      logic sysref_pin
);
    int cnt_q = 0;
    // ----
    // Pin low between requests
    // ----
    always @(posedge aclk)
    begin
        if (fire)
            cnt_q <= HIGH_CYC;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
    assign sysref_pin = (cnt_q != 0);
endmodule

// *** dv/tb_top.sv ***
// Bench for sync and chip mode control
`timescale 1ns/1ps
`include "scmc_regs.svh"
module tb_top
    import scmc_pkg::*;
;
    logic           aclk = 0;
    logic           aresetn = 0;
    logic           ce = 1;
    logic           fire = 0;
    logic           smp_valid = 0;
    logic           sysref_pin;
    scmc_axil_req_t req = '0;
    scmc_axil_rsp_t rsp;
    logic           out_valid_q, out_ctrl_q, div_reset_q, link_drop_q;
    logic           monitor_sync_q, q_enable, full_bw_mode, ddc0_only_mode;
    logic [15:0]    out_i_q, out_q_q;
    logic [2:0]     div_phase_q;
    logic [3:0]     app_mode;
    logic [31:0]    rdat;
    logic [1:0]     resp;
    int             err_count = 0;
    int             checked = 0;
    wire logic [3:0] rdy = {div_reset_q, rsp.rvalid, rsp.arready,
        rsp.bvalid};
    always #2 aclk = ~aclk;
    scmc_top scmc_top_inst (.aclk, .aresetn, .ce, .s_axil_req(req),
        .s_axil_rsp(rsp), .sysref_pin, .smp_valid, .smp_i(16'h1234),
        .smp_q(16'h5678), .out_valid_q, .out_i_q, .out_q_q, .out_ctrl_q,
        .div_phase_q, .div_reset_q, .link_drop_q, .monitor_sync_q,
        .q_enable, .full_bw_mode, .ddc0_only_mode, .app_mode);
    scmc_sysref_src scmc_sysref_src_inst (.aclk, .fire, .sysref_pin);
    // ----
    // Shared tasks
    // ----
    task stop_test;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task wt(input int k);
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end
        while (rdy[k] !== 1'b1 && n < 99);
        if (rdy[k] !== 1'b1)
        begin
            chk("wait", rdy[k], 1'b1);
            stop_test;
        end
    endtask
    task wr(input logic [13:0] a, input logic [31:0] d);
        int   n;
        logic pa, pw, ta, tw;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
            ta = pa && rsp.awready;
            tw = pw && rsp.wready;
            @(posedge aclk);
            if (ta)
            begin
                req.awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw)
            begin
                req.wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        while ((pa || pw) && n < 99);
        if (pa || pw)
        begin
            chk("wr_taken", {pa, pw}, 2'b00);
            stop_test;
        end
        wt(0);
        resp = rsp.bresp;
        @(posedge aclk);
        req.bready <= 1'b0;
    endtask
    task rd(input logic [13:0] a);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        wt(1);
        @(posedge aclk);
        req.arvalid <= 1'b0;
        wt(2);
        rdat = rsp.rdata;
        resp = rsp.rresp;
        @(posedge aclk);
        req.rready <= 1'b0;
    endtask
    task pulse;
        @(posedge aclk);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task t_reset;
        rd(`SCMC_SYNC_ADDR);
        chk("sync", rdat, 0);
        rd(`SCMC_MODE_ADDR);
        chk("mode", rdat, 0);
        @(negedge aclk);
        chk("q_en", q_enable, 1);
        chk("full_bw", full_bw_mode, 1);
    endtask
    task t_div;
        int g;
        for (g = 2; g < 6; g++)
        begin
            pulse;
            wt(3);
            chk("monitor", monitor_sync_q, 1);
            chk("phase", div_phase_q, 0);
            if (g > 2)
                chk("drop", link_drop_q, ((9 + g) % 4) != 0);
            repeat (g + 5) @(posedge aclk);
        end
    endtask
    task t_stat;
        rd(`SCMC_STAT_ADDR);
        chk("status", rdat, 32'h0000_0104);
        wr(`SCMC_STAT_ADDR, 32'h0000_0100);
        chk("bresp", resp, `SCMC_RESP_OKAY);
        rd(`SCMC_STAT_ADDR);
        chk("cleared", rdat, 32'h0000_0004);
    endtask
    task t_hold;
        logic [2:0] ph;
        @(posedge aclk);
        ce <= 1'b0;
        @(negedge aclk);
        ph = div_phase_q;
        repeat (3) @(negedge aclk);
        chk("hold", div_phase_q, ph);
        @(posedge aclk);
        ce <= 1'b1;
        repeat (2) @(negedge aclk);
        chk("run", div_phase_q, (ph + 3'h1) % 3'h4);
    endtask
    task t_rerst;
        wr(`SCMC_MODE_ADDR, 32'h0000_00ff);
        wr(`SCMC_SYNC_ADDR, 32'h0000_0001);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
    endtask
    task t_stamp;
        int n, s, m;
        wr(`SCMC_SYNC_ADDR, 8'h01);
        rd(`SCMC_SYNC_ADDR);
        chk("sync", rdat, 1);
        smp_valid <= 1'b1;
        pulse;
        s = 0;
        m = 0;
        for (n = 0; n < 20; n++)
        begin
            @(negedge aclk);
            s += (div_reset_q | link_drop_q | monitor_sync_q) !== 1'b0;
            m += out_ctrl_q === 1'b1;
        end
        chk("pulses", s, 0);
        chk("marks", m, 1);
        wr(`SCMC_SYNC_ADDR, 8'h00);
    endtask
    task t_mode;
        logic [7:0] wv [3] = '{8'hff, 8'h01, 8'h00};
        logic [7:0] rv [3] = '{8'hef, 8'h01, 8'h00};
        int k;
        for (k = 0; k < 3; k++)
        begin
            wr(`SCMC_MODE_ADDR, wv[k]);
            rd(`SCMC_MODE_ADDR);
            chk("mode", rdat, rv[k]);
            @(negedge aclk);
            chk("q_out", out_q_q, k ? 16'h5678 : 16'h0);
            chk("i_out", out_i_q, 16'h1234);
            chk("app", {full_bw_mode, ddc0_only_mode, app_mode},
                {k == 2, k == 1, rv[k][3:0]});
        end
    endtask
    task t_bad;
        rd(14'h0ff0);
        chk("rresp", resp, `SCMC_RESP_SLVERR);
        chk("rdata", rdat, 0);
        wr(14'h0ff0, 8'h01);
        chk("bresp", resp, `SCMC_RESP_SLVERR);
    endtask
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_div;
        t_stat;
        t_hold;
        t_stamp;
        t_mode;
        t_bad;
        t_rerst;
        stop_test;
    end
endmodule
